// ==== rtl/fpt_array.v ====
// flash cell array with and-only programming, block fill and stored protection words
`timescale 1ns/1ps
`default_nettype none
`include "fpt_regs.vh"

module fpt_array #(
  parameter ADDR_W = 14
) (
  // clock
  input wire mclk,
  input wire ce,
  // fetch read port
  input wire a_en,
  input wire [ADDR_W-3:0] a_word,
  output reg [31:0] a_data,
  // data read port, denied reads return zero
  input wire b_en,
  input wire b_allow,
  input wire [ADDR_W-3:0] b_word,
  output reg [31:0] b_data,
  // modify port
  input wire w_prog,
  input wire w_fill,
  input wire [ADDR_W-3:0] w_word,
  input wire [31:0] w_data,
  // stored protection words
  input wire nv_ppe_we,
  input wire nv_pre_we,
  input wire [31:0] nv_ppe_mask,
  input wire [31:0] nv_pre_mask,
  output reg [31:0] nv_ppe,
  output reg [31:0] nv_pre
);
  localparam WORDS = 1 << (ADDR_W - 2);

  // contents survive reset, so no reset term here
  reg [31:0] mem [0:WORDS-1];
  integer i;

  initial begin
    for (i = 0; i < WORDS; i = i + 1) begin
      mem[i] = `FPT_ERASED;
    end
    nv_ppe = `FPT_PROT_RST;
    nv_pre = `FPT_PRE_RST;
  end

  always @(posedge mclk) begin
    if (ce) begin
      if (a_en) begin
        a_data <= mem[a_word];
      end
      if (b_en) begin
        b_data <= b_allow ? mem[b_word] : 32'h00000000;
      end
      if (w_prog) begin
        mem[w_word] <= mem[w_word] & w_data;
      end else if (w_fill) begin
        mem[w_word] <= `FPT_ERASED;
      end
      if (nv_ppe_we) begin
        nv_ppe <= nv_ppe & nv_ppe_mask;
      end
      if (nv_pre_we) begin
        nv_pre <= nv_pre & nv_pre_mask;
      end
    end
  end
endmodule // fpt_array

`default_nettype wire

// ==== rtl/fpt_regs.vh ====
// register offsets, fields, reset values and timing for the flash protection block
`ifndef FPT_REGS_VH
`define FPT_REGS_VH

`define FPT_OFF_ADDR 8'h00
`define FPT_OFF_DATA 8'h04
`define FPT_OFF_CTRL 8'h08
`define FPT_OFF_RIS 8'h0C
`define FPT_OFF_MASK 8'h10
`define FPT_OFF_CLR 8'h14
`define FPT_OFF_USEC 8'h18
`define FPT_OFF_PPE 8'h1C
`define FPT_OFF_PRE 8'h20

`define FPT_CTRL_KEY 16'hA442
`define FPT_CTRL_WRITE 0
`define FPT_CTRL_ERASE 1
`define FPT_CTRL_COMMIT 3

`define FPT_RIS_ACCESS 0
`define FPT_RIS_DONE 1

`define FPT_DBG_HI 31
`define FPT_DBG_LO 30
`define FPT_DBG_ON 2'h2
`define FPT_DBG_COMMIT_ADDR 32'h00000900

`define FPT_PROT_RST 32'hFFFFFFFF
// shipped read enables: every block bit open, debug field at its enabling code
`define FPT_PRE_RST 32'hBFFFFFFF
`define FPT_ERASED 32'hFFFFFFFF

`define FPT_CLK_MHZ 8'hC8
`define FPT_USEC_RST (`FPT_CLK_MHZ - 8'h01)
`define FPT_PROG_US 8'h14
`define FPT_ERASE_US 8'h20
`define FPT_COMMIT_US 8'h10

`define FPT_BLOCK_SHIFT 10
`define FPT_REGION_SHIFT 11
`define FPT_WALK_LAST 8'hFF

`endif

// ==== rtl/fpt_top.v ====
// flash controller: timing tick, per-region protection, commit and debug disable
//
// Behaviour
// - flash splits into 1-KB blocks; erasing a block sets all its bits to one
// - programming a 32-bit word can only clear bits, never set them
// - each 2-KB region has one program-enable and one read-enable bit
// - execute-only region allows fetches only, no modify or data/debug read
// - reload resets to the value for the maximum clock rate
// - program or erase only proceeds while the region program-enable is one
// - read-enable one allows data reads; zero allows execution only
// - enable pairs: 00 execute-only, 10 write no read, 01 read-only, 11 open
// - a denied data read returns a bus fault to the requester
// - denied modify sets access status; interrupt only when masked in
// - all protection bits read one as shipped; read-enable ships as 0xBFFFFFFF here, debug field at 2
// - software writes can only clear protection bits
// - uncommitted clears are undone by reset; committed ones are permanent
// - protection becomes stored only through the commit command
// - top two read-enable bits form the debug enable field
// - debug disabled blocks debugger access; boundary scan stays usable
// - a committed debug disable can never be undone
// - literal loads on the data bus count as data reads
// - debug field value 2 enables debugger access; other values disable it
// - commit stores program-enable when address bit 0 is one, else read-enable
// - commit at address 0x900 also stores the debug enable field
//
// Decided for this implementation: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "fpt_regs.vh"

module fpt_top #(
  parameter ADDR_W = 14,
  parameter [7:0] PROG_US = `FPT_PROG_US,
  parameter [7:0] ERASE_US = `FPT_ERASE_US,
  parameter [7:0] COMMIT_US = `FPT_COMMIT_US
) (
  // clock and reset
  input wire mclk,
  input wire reset,
  input wire ce,
  // register port
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // instruction fetch bus
  input wire if_req,
  input wire [ADDR_W-1:0] if_addr,
  output wire [31:0] if_data,
  output reg if_valid,
  // data bus, debugger reads flagged
  input wire d_req,
  input wire d_dbg,
  input wire [ADDR_W-1:0] d_addr,
  output wire [31:0] d_data,
  output reg d_valid,
  output reg d_fault,
  // status
  output reg busy,
  output reg debug_access_port_en,
  output reg access_irq
);
  localparam ST_LOAD = 3'd0;
  localparam ST_IDLE = 3'd1;
  localparam ST_WAIT = 3'd2;
  localparam ST_PROG = 3'd3;
  localparam ST_ERASE = 3'd4;
  localparam ST_COMMIT = 3'd5;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] flash_address_register_q;
  reg [31:0] data_q;
  reg [3:0] flash_control_register_q;
  reg [3:0] ctrl_d;
  reg [7:0] microsecond_reload_q;
  reg [7:0] tick_cnt_q;
  reg [7:0] us_cnt_q;
  reg [7:0] us_cnt_d;
  reg [7:0] walk_q;
  reg [7:0] walk_d;
  reg [31:0] program_enable_register_q;
  reg [31:0] read_enable_register_q;
  reg [1:0] ris_q;
  reg [1:0] ris_set;
  reg [1:0] ris_clr;
  reg [1:0] flash_interrupt_mask_q;
  reg [31:0] rd_mux;

  wire tick;
  wire ctrl_wr;
  wire key_ok;
  wire [31:0] nv_ppe;
  wire [31:0] nv_pre;
  wire [31:0] pre_eff;
  wire [31:0] pre_commit;
  wire [4:0] mod_region;
  wire [4:0] rd_region;
  wire mod_allowed;
  wire rd_allowed;
  wire idle;
  wire w_prog;
  wire w_fill;
  wire [ADDR_W-3:0] w_word;

  assign idle = (state_q == ST_IDLE);
  assign tick = (tick_cnt_q == 8'h00);
  assign ctrl_wr = reg_wr && (reg_addr == `FPT_OFF_CTRL);
  assign key_ok = (reg_wdata[31:16] == `FPT_CTRL_KEY);

  // debug field overrides the two top read-enable bits
  assign pre_eff = {2'b11, read_enable_register_q[29:0]};
  assign mod_region = {{(5-(ADDR_W-11)){1'b0}},
    flash_address_register_q[ADDR_W-1:`FPT_REGION_SHIFT]};
  assign rd_region = {{(5-(ADDR_W-11)){1'b0}}, d_addr[ADDR_W-1:`FPT_REGION_SHIFT]};
  assign mod_allowed = program_enable_register_q[mod_region];
  // literal loads arrive on the data bus like any other data read
  assign rd_allowed = pre_eff[rd_region] &&
    (!d_dbg || debug_access_port_en);

  // a plain read-enable commit leaves the debug field untouched
  assign pre_commit = (flash_address_register_q == `FPT_DBG_COMMIT_ADDR) ?
    read_enable_register_q : {2'b11, read_enable_register_q[29:0]};

  assign w_prog = (state_q == ST_PROG);
  assign w_fill = (state_q == ST_ERASE);
  assign w_word = w_fill ?
    {flash_address_register_q[ADDR_W-1:`FPT_BLOCK_SHIFT], walk_q} :
    flash_address_register_q[ADDR_W-1:2];

  fpt_array #(
    .ADDR_W(ADDR_W)
  ) u_array (
    .mclk(mclk),
    .ce(ce),
    .a_en(if_req && idle),
    .a_word(if_addr[ADDR_W-1:2]),
    .a_data(if_data),
    .b_en(d_req && idle),
    .b_allow(rd_allowed),
    .b_word(d_addr[ADDR_W-1:2]),
    .b_data(d_data),
    .w_prog(w_prog),
    .w_fill(w_fill),
    .w_word(w_word),
    .w_data(data_q),
    .nv_ppe_we((state_q == ST_COMMIT) && flash_address_register_q[0]),
    .nv_pre_we((state_q == ST_COMMIT) && !flash_address_register_q[0]),
    .nv_ppe_mask(program_enable_register_q),
    .nv_pre_mask(pre_commit),
    .nv_ppe(nv_ppe),
    .nv_pre(nv_pre)
  );

  // microsecond tick; wrong reload only stretches or shrinks flash timing
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      tick_cnt_q <= `FPT_USEC_RST;
    end else if (ce) begin
      if (tick) begin
        tick_cnt_q <= microsecond_reload_q;
      end else begin
        tick_cnt_q <= tick_cnt_q - 8'h01;
      end
    end
  end

  // command sequencer
  always @* begin
    state_d = state_q;
    ctrl_d = flash_control_register_q;
    us_cnt_d = us_cnt_q;
    walk_d = walk_q;
    ris_set = 2'b00;
    case (state_q)
      ST_LOAD: begin
        state_d = ST_IDLE;
      end
      ST_IDLE: begin
        if (ctrl_wr && key_ok) begin
          if (reg_wdata[`FPT_CTRL_WRITE] || reg_wdata[`FPT_CTRL_ERASE]) begin
            if (mod_allowed) begin
              ctrl_d = {2'b00, reg_wdata[`FPT_CTRL_ERASE] &&
                !reg_wdata[`FPT_CTRL_WRITE], reg_wdata[`FPT_CTRL_WRITE]};
              us_cnt_d = reg_wdata[`FPT_CTRL_WRITE] ? PROG_US : ERASE_US;
              state_d = ST_WAIT;
            end else begin
              ris_set[`FPT_RIS_ACCESS] = 1'b1;
            end
          end else if (reg_wdata[`FPT_CTRL_COMMIT]) begin
            ctrl_d = 4'b1000;
            us_cnt_d = COMMIT_US;
            state_d = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (tick) begin
          if (us_cnt_q == 8'h00) begin
            walk_d = 8'h00;
            if (flash_control_register_q[`FPT_CTRL_WRITE]) begin
              state_d = ST_PROG;
            end else if (flash_control_register_q[`FPT_CTRL_ERASE]) begin
              state_d = ST_ERASE;
            end else begin
              state_d = ST_COMMIT;
            end
          end else begin
            us_cnt_d = us_cnt_q - 8'h01;
          end
        end
      end
      ST_PROG: begin
        ctrl_d = 4'b0000;
        ris_set[`FPT_RIS_DONE] = 1'b1;
        state_d = ST_IDLE;
      end
      ST_ERASE: begin
        walk_d = walk_q + 8'h01;
        if (walk_q == `FPT_WALK_LAST) begin
          ctrl_d = 4'b0000;
          ris_set[`FPT_RIS_DONE] = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_COMMIT: begin
        ctrl_d = 4'b0000;
        ris_set[`FPT_RIS_DONE] = 1'b1;
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_LOAD;
      end
    endcase
  end

  always @* begin
    ris_clr = 2'b00;
    if (reg_wr && (reg_addr == `FPT_OFF_CLR)) begin
      ris_clr = reg_wdata[1:0];
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= ST_LOAD;
      flash_control_register_q <= 4'b0000;
      us_cnt_q <= 8'h00;
      walk_q <= 8'h00;
      ris_q <= 2'b00;
      busy <= 1'b1;
      access_irq <= 1'b0;
    end else if (ce) begin
      state_q <= state_d;
      flash_control_register_q <= ctrl_d;
      us_cnt_q <= us_cnt_d;
      walk_q <= walk_d;
      // a new event wins over a clear in the same cycle
      ris_q <= (ris_q & ~ris_clr) | ris_set;
      busy <= (state_d != ST_IDLE);
      access_irq <= |(ris_q & flash_interrupt_mask_q);
    end
  end

  // software registers
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      flash_address_register_q <= 32'h00000000;
      data_q <= 32'h00000000;
      microsecond_reload_q <= `FPT_USEC_RST;
      flash_interrupt_mask_q <= 2'b00;
      program_enable_register_q <= `FPT_PROT_RST;
      read_enable_register_q <= `FPT_PRE_RST;
      debug_access_port_en <= 1'b0;
    end else if (ce) begin
      if (state_q == ST_LOAD) begin
        // stored words reload here, undoing uncommitted clears
        program_enable_register_q <= nv_ppe;
        read_enable_register_q <= nv_pre;
        // debug setting takes effect only in the load state after a reset
        debug_access_port_en <=
          (nv_pre[`FPT_DBG_HI:`FPT_DBG_LO] == `FPT_DBG_ON);
      end else if (reg_wr) begin
        case (reg_addr)
          `FPT_OFF_ADDR: begin
            if (idle) begin
              flash_address_register_q <= reg_wdata;
            end
          end
          `FPT_OFF_DATA: begin
            if (idle) begin
              data_q <= reg_wdata;
            end
          end
          `FPT_OFF_USEC: begin
            microsecond_reload_q <= reg_wdata[7:0];
          end
          `FPT_OFF_MASK: begin
            flash_interrupt_mask_q <= reg_wdata[1:0];
          end
          `FPT_OFF_PPE: begin
            program_enable_register_q <= program_enable_register_q & reg_wdata;
          end
          `FPT_OFF_PRE: begin
            read_enable_register_q <= read_enable_register_q & reg_wdata;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // read mux
  always @* begin
    case (reg_addr)
      `FPT_OFF_ADDR: rd_mux = flash_address_register_q;
      `FPT_OFF_DATA: rd_mux = data_q;
      `FPT_OFF_CTRL: rd_mux = {28'h0000000, flash_control_register_q};
      `FPT_OFF_RIS: rd_mux = {30'h0, ris_q};
      `FPT_OFF_MASK: rd_mux = {30'h0, flash_interrupt_mask_q};
      `FPT_OFF_CLR: rd_mux = {30'h0, ris_q & flash_interrupt_mask_q};
      `FPT_OFF_USEC: rd_mux = {24'h000000, microsecond_reload_q};
      `FPT_OFF_PPE: rd_mux = program_enable_register_q;
      `FPT_OFF_PRE: rd_mux = read_enable_register_q;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h00000000;
      if_valid <= 1'b0;
      d_valid <= 1'b0;
      d_fault <= 1'b0;
    end else if (ce) begin
      reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      // flash is unreadable while it is being modified
      if_valid <= if_req && idle;
      d_valid <= d_req && idle;
      d_fault <= d_req && idle && !rd_allowed;
    end
  end
endmodule // fpt_top

`default_nettype wire

// ==== testbench/flash_protection_timing_tb_top.sv ====
// self-checking bench for the flash protection block
`timescale 1ns/1ps
`default_nettype none
`include "fpt_regs.vh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module flash_protection_timing_tb_top;
  logic mclk, reset, ce, reg_wr, reg_rd, if_req, d_req, d_dbg;
  logic if_valid, d_valid, d_fault, busy, dbg_en, access_irq, f;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, if_data, d_data, v, dw, dw2;
  logic [31:0] ppe = 32'hFFFFFFFA;
  logic [31:0] pre = 32'hFFFFFFF9;
  logic [13:0] if_addr, d_addr, a;
  int num_errors, n_compared;
  fpt_top #(.PROG_US(8'h01), .ERASE_US(8'h01), .COMMIT_US(8'h01)) dut (
    .mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .if_req(if_req),
    .if_addr(if_addr), .if_data(if_data), .if_valid(if_valid), .d_req(d_req),
    .d_dbg(d_dbg), .d_addr(d_addr), .d_data(d_data), .d_valid(d_valid), .d_fault(d_fault),
    .busy(busy), .debug_access_port_en(dbg_en), .access_irq(access_irq));
  fpt_cpu_model cpu (
    .mclk(mclk), .busy(busy), .if_req(if_req), .if_addr(if_addr), .if_data(if_data),
    .if_valid(if_valid), .d_req(d_req), .d_dbg(d_dbg), .d_addr(d_addr), .d_data(d_data),
    .d_valid(d_valid), .d_fault(d_fault));
  always #2.5 mclk = ~mclk;
  function automatic logic [31:0] exp_word(input logic ok, input logic [31:0] o, n);
    return ok ? (o & n) : o;
  endfunction
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= ad;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic results();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // polls busy under a bound; control must show the command only while it runs
  task automatic cmd(input logic [31:0] ad, input logic [31:0] c, input logic run);
    int n;
    n = 0;
    wr(`FPT_OFF_ADDR, ad);
    wr(`FPT_OFF_CTRL, {`FPT_CTRL_KEY, 16'h0} | c);
    rd(`FPT_OFF_CTRL, v);
    `CHK("ctrl run", run ? c : 32'h0, v)
    while (busy !== 1'b0 && n < 5000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 5000) begin
      num_errors++;
      results();
    end
    rd(`FPT_OFF_CTRL, v);
    `CHK("ctrl done", 32'h0, v)
  endtask
  task automatic prog(input logic [13:0] ad, input logic [31:0] d, input logic run);
    wr(`FPT_OFF_DATA, d);
    cmd({18'h0, ad}, 32'h1, run);
  endtask
  task automatic do_reset();
    reset <= 1'b1;
    repeat (6) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
  endtask
  initial begin
    mclk = 1'b0;
    reset = 1'b1;
    ce = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    num_errors = 0;
    n_compared = 0;
    dw = $urandom(11);
    do_reset();
    rd(`FPT_OFF_USEC, v);
    `CHK("reload", ({24'h0, `FPT_USEC_RST}), v)
    rd(`FPT_OFF_PPE, v);
    `CHK("ppe", 32'hFFFFFFFF, v)
    rd(`FPT_OFF_PRE, v);
    `CHK("pre", `FPT_PRE_RST, v)
    `CHK("dbg on", 1'b1, dbg_en)
    rd(8'hFC, v);
    `CHK("unmapped", 32'h0, v)
    wr(`FPT_OFF_USEC, 32'h1); // short ticks keep the run brief
    dw = $urandom;
    dw2 = $urandom;
    prog(14'h0404, dw, 1'b1);
    prog(14'h03FC, dw2, 1'b1);
    prog(14'h0404, dw2, 1'b1);
    cpu.dread(1'b0, 14'h0404, v, f);
    `CHK("and prog", dw & dw2, v)
    cmd(32'h400, 32'h2, 1'b1);
    cpu.dread(1'b0, 14'h0404, v, f);
    `CHK("erased", 32'hFFFFFFFF, v)
    cpu.fetch(14'h03FC, v);
    `CHK("neighbour", dw2, v)
    wr(`FPT_OFF_PPE, ppe);
    wr(`FPT_OFF_PRE, pre);
    wr(`FPT_OFF_PPE, 32'hFFFFFFFF);
    rd(`FPT_OFF_PPE, v);
    `CHK("no set", ppe, v)
    // a write while the clock enable is low must not land
    ce <= 1'b0;
    wr(`FPT_OFF_USEC, 32'h5);
    ce <= 1'b1;
    rd(`FPT_OFF_USEC, v);
    `CHK("frozen", 32'h1, v)
    for (int r = 0; r < 4; r++) begin
      a = 14'(r * 32'h800 + 32'h10 + ($urandom % 4) * 4);
      dw = $urandom;
      wr(`FPT_OFF_CLR, 32'h3);
      prog(a, dw, ppe[r]);
      rd(`FPT_OFF_RIS, v);
      `CHK("viol", ~ppe[r], v[0])
      cpu.dread(1'b0, a, v, f);
      `CHK("fault", ~pre[r], f)
      `CHK("data", pre[r] ? exp_word(ppe[r], 32'hFFFFFFFF, dw) : 32'h0, v)
      cpu.fetch(a, v);
      `CHK("fetch", exp_word(ppe[r], 32'hFFFFFFFF, dw), v)
      cpu.dread(1'b1, a, v, f);
      `CHK("dbg fault", ~pre[r], f)
    end
    // region 3 is open; a refused write to region 2 leaves the violation pending
    prog(14'h1020, 32'h0, 1'b0);
    `CHK("irq masked", 1'b0, access_irq)
    wr(`FPT_OFF_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK("irq on", 1'b1, access_irq)
    wr(`FPT_OFF_CLR, 32'h3);
    repeat (2) @(posedge mclk);
    `CHK("irq off", 1'b0, access_irq)
    cmd(32'h1, 32'h8, 1'b1);
    do_reset();
    rd(`FPT_OFF_PPE, v);
    `CHK("ppe kept", ppe, v)
    rd(`FPT_OFF_PRE, v);
    `CHK("pre back", `FPT_PRE_RST, v)
    wr(`FPT_OFF_USEC, 32'h1);
    wr(`FPT_OFF_PRE, 32'h3FFFFFFF);
    // regions 1 and 3 stay programmable, so an update path survives
    cmd(32'h900, 32'h8, 1'b1);
    do_reset();
    `CHK("dbg off", 1'b0, dbg_en)
    wr(`FPT_OFF_PRE, 32'hFFFFFFFF);
    rd(`FPT_OFF_PRE, v);
    `CHK("pre stored", 32'h3FFFFFFF, v)
    cpu.dread(1'b1, 14'h3000, v, f);
    `CHK("dbg denied", 1'b1, f)
    cpu.dread(1'b0, 14'h3000, v, f);
    `CHK("cpu allowed", 1'b0, f)
    results();
  end
endmodule // flash_protection_timing_tb_top
bind fpt_top fpt_top_properties u_props (
  .mclk(mclk), .reset(reset), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .if_req(if_req), .if_valid(if_valid), .d_req(d_req), .d_dbg(d_dbg),
  .d_data(d_data), .d_valid(d_valid), .d_fault(d_fault), .busy(busy),
  .debug_access_port_en(debug_access_port_en));
`default_nettype wire

// ==== testbench/fpt_cpu_model.sv ====
// processor and debugger read buses facing the flash block
`timescale 1ns/1ps
`default_nettype none
module fpt_cpu_model (
  // clock and flash state
  input wire logic mclk,
  input wire logic busy,
  // fetch bus
  output logic if_req,
  output logic [13:0] if_addr,
  input wire logic [31:0] if_data,
  input wire logic if_valid,
  // data bus
  output logic d_req,
  output logic d_dbg,
  output logic [13:0] d_addr,
  input wire logic [31:0] d_data,
  input wire logic d_valid,
  input wire logic d_fault
);
  initial begin
    if_req = 1'b0;
    if_addr = 14'h0;
    d_req = 1'b0;
    d_dbg = 1'b0;
    d_addr = 14'h0;
  end
  // request held until an edge sees the flash idle; released lines show the inverse
  task automatic fetch(input logic [13:0] a, output logic [31:0] v);
    int n;
    n = 0;
    if_req <= 1'b1;
    if_addr <= a;
    do begin
      @(posedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 4000);
    if_req <= 1'b0;
    if_addr <= ~a;
    @(posedge mclk);
    v = (if_valid === 1'b1) ? if_data : 32'hX;
  endtask
  // literal loads go out here with the debugger flag low
  task automatic dread(input logic dbg, input logic [13:0] a, output logic [31:0] v,
                       output logic f);
    int n;
    n = 0;
    d_req <= 1'b1;
    d_dbg <= dbg;
    d_addr <= a;
    do begin
      @(posedge mclk);
      n++;
    end while (busy !== 1'b0 && n < 4000);
    d_req <= 1'b0;
    d_dbg <= ~dbg;
    d_addr <= ~a;
    @(posedge mclk);
    v = (d_valid === 1'b1) ? d_data : 32'hX;
    f = (d_valid === 1'b1) ? d_fault : 1'bX;
  endtask
endmodule // fpt_cpu_model
`default_nettype wire

// ==== testbench/fpt_top_properties.sv ====
// port assertions for the flash protection block
`timescale 1ns/1ps
`default_nettype none
module fpt_top_properties (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  // read buses
  input wire logic if_req,
  input wire logic if_valid,
  input wire logic d_req,
  input wire logic d_dbg,
  input wire logic [31:0] d_data,
  input wire logic d_valid,
  input wire logic d_fault,
  // status
  input wire logic busy,
  input wire logic debug_access_port_en
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic cmt_wr;
  assign cmt_wr = reg_wr && ce && !busy && reg_addr == 8'h08 && reg_wdata == 32'hA4420008;
  AST_FETCH_ANSWER: assert property (if_req && ce && !busy |=> if_valid)
    else $error("fetch not answered");
  AST_DATA_ANSWER: assert property (d_req && ce && !busy |=> d_valid)
    else $error("data read not answered");
  AST_HELD_WHEN_BUSY: assert property (busy && ce |=> !if_valid && !d_valid)
    else $error("read answered during an operation");
  AST_FAULT_WITH_VALID: assert property (d_fault |-> d_valid)
    else $error("fault without a read answer");
  AST_FAULT_ZERO_DATA: assert property (d_fault |-> d_data == 32'h0)
    else $error("denied read leaked data");
  AST_DEBUG_BLOCKED: assert property (d_req && d_dbg && ce && !busy && !debug_access_port_en |=> d_fault)
    else $error("debugger read not refused");
  AST_COMMIT_BUSY: assert property (cmt_wr |=> busy [*2])
    else $error("commit did not hold busy");
  AST_DEBUG_HELD: assert property (!busy && !$past(busy) |-> $stable(debug_access_port_en))
    else $error("debug enable moved outside reset load");
  cover property (d_fault);
  cover property (cmt_wr);
  cover property (if_valid && d_valid);
endmodule // fpt_top_properties
`default_nettype wire
